/* File: rtl/bsds_top.sv */
// Functional notes
// - Start only with supply, enable and dimming.
// - Detection window picks single-wire or pulse-width.
// - Window timing starts at enabling edge.
// - Low pulse done before 1ms selects single-wire.
// - Grounded feedback pin disables its channel.
// - Both pins grounded: startup does not proceed.
// - Soft-start only after feedback check.
// - Enable low 2.5ms or dimming low 20ms: shutdown.
// - Reduced limit first 5ms, then normal limit.
// - One command carries the 9-bit code.
// - Code register starts at all ones.
// - Stored code scales channel current.
// - Shutdown returns code to all ones.
// - Dimming tied high: enable alone controls.
// - Dimming driven: both pins needed.
// - Command is 24 bits, address then data.
`timescale 1ns/1ns
`default_nettype none
module bsds_top
  import bsds_pkg::*;
#(
  parameter int               P_TICK_CYCLES = TICK_CYCLES,
  parameter logic [TMR_W-1:0] P_WINDOW_US   = DETECT_WINDOW_US,
  parameter logic [TMR_W-1:0] P_EN_OFF_US   = EN_OFF_US,
  parameter logic [TMR_W-1:0] P_DIM_OFF_US  = DIM_OFF_US,
  parameter logic [TMR_W-1:0] P_REDUCED_US  = REDUCED_LIMIT_US
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone classic slave.
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Device pins and analog status.
  input  wire logic               supply_ok_i,
  input  wire logic               enable_pin_i,
  input  wire logic               dimming_pin_i,
  input  wire logic               sink_feedback_pin_one_i,
  input  wire logic               sink_feedback_pin_two_i,
  // Received single-wire command frame.
  input  wire logic               frame_valid_i,
  input  wire logic [FRAME_W-1:0] frame_i,
  // Control outputs to the analog section.
  output logic                    regulator_on_o,
  output logic                    single_wire_sel_o,
  output logic                    pwm_sel_o,
  output logic      [1:0]         chan_en_o,
  output logic                    boost_en_o,
  output logic                    reduced_limit_o,
  output logic      [CODE_W-1:0]  brightness_code_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam int TB_W = 16;
  localparam logic [TB_W-1:0] TB_LAST = TB_W'(P_TICK_CYCLES - 1);

  bsds_state_t      state;       // Sequencer state.
  bsds_state_t      next_state;  // Sequencer next state.
  logic [TB_W-1:0]  tb_cnt;      // Time-base divider count.
  logic             tick;        // One-cycle microsecond enable.
  logic             en_q;        // Enable pin one cycle ago.
  logic             en_rise;     // Enable pin low-to-high edge.
  logic             pulse_ok;    // Detect low pulse began late enough.
  logic             hold_off;    // Software hold in shutdown.
  logic             en_off;      // Enable low too long.
  logic             dim_off;     // Dimming low too long.
  logic             go_off;      // Any shutdown cause.
  logic             start_ok;    // All start conditions met.
  logic             detect_hit;  // Single-wire pattern seen.
  logic             frame_hit;   // Command addressed to this device.
  logic             wb_req;      // A new bus request this cycle.
  logic [31:0]      rd_data;     // Read mux output.

  bsds_tmr_if #(.W(TMR_W)) seq_tmr ();  // Window and soft-start.
  bsds_tmr_if #(.W(TMR_W)) enl_tmr ();  // Enable pin low time.
  bsds_tmr_if #(.W(TMR_W)) dml_tmr ();  // Dimming pin low time.

  // ************************************************************
  // Time base
  // ************************************************************
  // One divider serves every duration, so all counters step in lock.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_cnt <= '0;
      tick   <= 1'b0;
    end else if (tb_cnt == TB_LAST) begin
      tb_cnt <= '0;
      tick   <= 1'b1;
    end else begin
      tb_cnt <= tb_cnt + 1'b1;
      tick   <= 1'b0;
    end
  end

  // ************************************************************
  // Duration counters
  // ************************************************************
  // The window timer runs in detection, and again during soft-start.
  assign seq_tmr.tick = tick;
  assign seq_tmr.run  = (state == ST_DETECT) || (state == ST_SOFT);
  assign seq_tmr.clr  = (next_state != state);

  // The enable low timer measures both the detect pulse and shutdown.
  assign enl_tmr.tick = tick;
  assign enl_tmr.run  = !enable_pin_i;
  assign enl_tmr.clr  = enable_pin_i || (state == ST_OFF);

  // The dimming low timer also runs in shutdown, so a dead dimming
  // line keeps the device from starting on an enable edge.
  assign dml_tmr.tick = tick;
  assign dml_tmr.run  = !dimming_pin_i;
  assign dml_tmr.clr  = dimming_pin_i;

  bsds_timer #(.W(TMR_W)) u_seq_tmr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (seq_tmr.timer)
  );

  bsds_timer #(.W(TMR_W)) u_enl_tmr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (enl_tmr.timer)
  );

  bsds_timer #(.W(TMR_W)) u_dml_tmr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (dml_tmr.timer)
  );

  // ************************************************************
  // Conditions
  // ************************************************************
  assign en_rise  = enable_pin_i && !en_q;
  // Both pins are watched in every mode; a tied-high dimming pin
  // simply never times out, leaving the enable pin in charge.
  assign en_off   = enl_tmr.count > P_EN_OFF_US;
  assign dim_off  = dml_tmr.count > P_DIM_OFF_US;
  assign go_off   = !supply_ok_i || hold_off || en_off || dim_off;
  // A fresh enable edge, supply, and a live dimming pin are needed.
  assign start_ok = supply_ok_i && !hold_off && en_rise && !dim_off;
  // The low pulse must have lasted past the detect time inside the window.
  assign detect_hit = pulse_ok && !enable_pin_i
                   && (enl_tmr.count > DETECT_LOW_US)
                   && (seq_tmr.count < P_WINDOW_US);
  assign frame_hit = frame_valid_i
                  && (frame_i[ADDR_LSB +: ADDR_W] == DEVICE_ADDR);

  // Edge detector register for the enable pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable_pin_i;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Next-state logic; shutdown causes win over every other step.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: begin
        if (start_ok) begin
          next_state = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (seq_tmr.count >= P_WINDOW_US) begin
          next_state = ST_FB_CHECK;
        end
      end
      ST_FB_CHECK: begin
        if (sink_feedback_pin_one_i && sink_feedback_pin_two_i) begin
          next_state = ST_HALT;
        end else begin
          next_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (seq_tmr.count >= P_REDUCED_US) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
    endcase
    if (go_off && (state != ST_OFF)) begin
      next_state = ST_OFF;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Interface detection
  // ************************************************************
  // A low pulse counts only if it starts after the detect delay.
  always_ff @(posedge clk_i) begin
    if (rst_i || (state != ST_DETECT)) begin
      pulse_ok <= 1'b0;
    end else if (en_q && !enable_pin_i) begin
      pulse_ok <= seq_tmr.count >= DETECT_DELAY_US;
    end
  end

  // Selection is latched once and forgotten in shutdown, so the host
  // must give the pattern again after every shutdown.
  always_ff @(posedge clk_i) begin
    if (rst_i || (state == ST_OFF)) begin
      single_wire_sel_o <= 1'b0;
      pwm_sel_o         <= 1'b0;
    end else if ((state == ST_DETECT) && detect_hit) begin
      single_wire_sel_o <= 1'b1;
    end else if ((state == ST_DETECT) && (next_state == ST_FB_CHECK)
                 && !single_wire_sel_o) begin
      pwm_sel_o         <= 1'b1;
    end
  end

  // ************************************************************
  // Channels, boost and current limit
  // ************************************************************
  // Channels are judged once, at the feedback check, and kept.
  always_ff @(posedge clk_i) begin
    if (rst_i || (next_state == ST_OFF)) begin
      chan_en_o <= 2'b00;
    end else if (state == ST_FB_CHECK) begin
      chan_en_o <= {!sink_feedback_pin_two_i, !sink_feedback_pin_one_i};
    end
  end

  // Outputs that follow the next state, so they switch with the state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regulator_on_o  <= 1'b0;
      boost_en_o      <= 1'b0;
      reduced_limit_o <= 1'b0;
    end else begin
      regulator_on_o  <= next_state != ST_OFF;
      boost_en_o      <= (next_state == ST_SOFT) || (next_state == ST_RUN);
      reduced_limit_o <= next_state == ST_SOFT;
    end
  end

  // ************************************************************
  // Brightness code
  // ************************************************************
  // Commands are taken only once single-wire mode is chosen and the
  // sequence is past detection; the analog side scales by code/511.
  // The default returns in the same cycle as the regulator drops, so
  // no shutdown ever shows a stale code beside a dark output.
  always_ff @(posedge clk_i) begin
    if (rst_i || (next_state == ST_OFF)) begin
      brightness_code_o <= CODE_DEFAULT;
    end else if (frame_hit && single_wire_sel_o
                 && ((state == ST_SOFT) || (state == ST_RUN))) begin
      brightness_code_o <= frame_i[CODE_W-1:0];
    end
  end

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  // A request is answered one cycle later; ack drops after one cycle.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Acknowledge and read data register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : '0;
    end
  end

  // Read mux; unmapped addresses read as zero and still acknowledge.
  always_comb begin
    rd_data = '0;
    unique case (wb_adr_i)
      REG_CTRL: begin
        rd_data[CTRL_HOLD_OFF] = hold_off;
      end
      REG_STATUS: begin
        rd_data[ST_STATE_LSB +: 4] = state;
        rd_data[ST_SINGLE]         = single_wire_sel_o;
        rd_data[ST_PWM]            = pwm_sel_o;
        rd_data[ST_CH_LSB +: 2]    = chan_en_o;
        rd_data[ST_REDUCED]        = reduced_limit_o;
        rd_data[ST_BOOST]          = boost_en_o;
        rd_data[ST_REG_ON]         = regulator_on_o;
      end
      REG_CODE: begin
        rd_data[CODE_W-1:0] = brightness_code_o;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  // Control register write; takes effect at the edge where ack rises.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_off <= 1'b0;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_CTRL)) begin
      hold_off <= wb_dat_i[CTRL_HOLD_OFF];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/bsds_pkg.sv */
package bsds_pkg;

  // ************************************************************
  // Time base
  // ************************************************************
  // The core clock rate in MHz (a period of 4 ns).
  localparam int CLK_MHZ         = 250;
  // One time-base tick lasts one microsecond.
  localparam int TICK_NS         = 1000;
  // Clock cycles per tick, derived from the tick period and the clock rate.
  localparam int TICK_CYCLES     = (TICK_NS * CLK_MHZ) / 1000;

  // ************************************************************
  // Durations, in microseconds (time-base ticks)
  // ************************************************************
  localparam int TMR_W           = 15;
  // Least wait after the enabling edge before the detect low pulse.
  localparam logic [TMR_W-1:0] DETECT_DELAY_US  = 15'd100;
  // Least low time of the enable pin that selects single-wire mode.
  localparam logic [TMR_W-1:0] DETECT_LOW_US    = 15'd260;
  // Length of the detection window from the enabling edge.
  localparam logic [TMR_W-1:0] DETECT_WINDOW_US = 15'd1000;
  // Enable pin low time that forces shutdown.
  localparam logic [TMR_W-1:0] EN_OFF_US        = 15'd2500;
  // Dimming pin low time that forces shutdown.
  localparam logic [TMR_W-1:0] DIM_OFF_US       = 15'd20000;
  // Time spent at the reduced switch current limit.
  localparam logic [TMR_W-1:0] REDUCED_LIMIT_US = 15'd5000;

  // ************************************************************
  // Single-wire command frame
  // ************************************************************
  localparam int FRAME_W         = 24;
  localparam int ADDR_LSB        = 16;
  localparam int ADDR_W          = 8;
  localparam logic [ADDR_W-1:0] DEVICE_ADDR = 8'h8F;
  localparam int CODE_W          = 9;
  localparam logic [CODE_W-1:0] CODE_DEFAULT = 9'h1FF;

  // ************************************************************
  // Register map (byte addresses on the Wishbone bus)
  // ************************************************************
  localparam int ADR_W           = 8;
  localparam logic [ADR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_CODE   = 8'h08;
  // Control field: hold the device in shutdown.
  localparam int CTRL_HOLD_OFF   = 0;
  // Status field positions.
  localparam int ST_STATE_LSB    = 0;
  localparam int ST_SINGLE       = 4;
  localparam int ST_PWM          = 5;
  localparam int ST_CH_LSB       = 6;
  localparam int ST_REDUCED      = 8;
  localparam int ST_BOOST        = 9;
  localparam int ST_REG_ON       = 10;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_OFF,
    ST_DETECT,
    ST_FB_CHECK,
    ST_SOFT,
    ST_RUN,
    ST_HALT
  } bsds_state_t;

endpackage

/* File: rtl/bsds_tmr_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Carries one duration counter between the sequencer and a timer.
interface bsds_tmr_if #(
  parameter int W = 15
);
  logic         clr;    // Clear the count, wins over counting.
  logic         run;    // Count while high, on each tick.
  logic         tick;   // One-cycle time-base enable.
  logic [W-1:0] count;  // Elapsed ticks, saturating.

  modport owner (output clr, output run, output tick, input count);
  modport timer (input clr, input run, input tick, output count);
endinterface
`default_nettype wire

/* File: rtl/bsds_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module bsds_timer #(
  parameter int W = 15
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  bsds_tmr_if.timer  t
);

  // ************************************************************
  // Saturating tick counter
  // ************************************************************
  localparam logic [W-1:0] CNT_MAX = '1;

  // Saturation keeps a long low level from wrapping back to a short one.
  always_ff @(posedge clk_i) begin
    if (rst_i || t.clr) begin
      t.count <= '0;
    end else if (t.run && t.tick && (t.count != CNT_MAX)) begin
      t.count <= t.count + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: test/bsds_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// Startup sequence checker
// ********
module bsds_checker
  import bsds_pkg::*;
#(
  parameter int               P_TICK_CYCLES = TICK_CYCLES,
  parameter logic [TMR_W-1:0] P_EN_OFF_US   = EN_OFF_US
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               supply_ok_i,
  input wire logic               enable_pin_i,
  input wire logic               dimming_pin_i,
  input wire logic               sink_feedback_pin_one_i,
  input wire logic               sink_feedback_pin_two_i,
  input wire logic               frame_valid_i,
  input wire logic [FRAME_W-1:0] frame_i,
  input wire logic               regulator_on_o,
  input wire logic               single_wire_sel_o,
  input wire logic               pwm_sel_o,
  input wire logic [1:0]         chan_en_o,
  input wire logic               boost_en_o,
  input wire logic               reduced_limit_o,
  input wire logic [CODE_W-1:0]  brightness_code_o
);
  // Two ticks and two cycles of slack cover the divider phase and the output register.
  localparam int EN_LIM = int'(P_EN_OFF_US) * P_TICK_CYCLES + 2 * P_TICK_CYCLES + 2;
  logic [15:0] en_low_cnt;  // Enable-low cycles, saturating so it never wraps.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Count how long the enable pin has been low.
  always_ff @(posedge clk_i) begin
    if (rst_i || enable_pin_i) begin
      en_low_cnt <= '0;
    end else if (en_low_cnt != 16'hFFFF) begin
      en_low_cnt <= en_low_cnt + 16'h0001;
    end
  end

  sequence s_boost_up;
    $rose(boost_en_o);
  endsequence
  sequence s_good_frame;
    frame_valid_i && single_wire_sel_o && boost_en_o && frame_i[23:16] == DEVICE_ADDR;
  endsequence

  property p_supply;
    !supply_ok_i |=> !regulator_on_o;
  endproperty
  a_supply: assert property (p_supply) else $error("regulator on without supply");
  property p_start;
    $rose(regulator_on_o) |-> $past(supply_ok_i) && $past(dimming_pin_i);
  endproperty
  a_start: assert property (p_start) else $error("start without conditions");
  property p_single;
    $rose(single_wire_sel_o) |-> !$past(enable_pin_i) && !pwm_sel_o;
  endproperty
  a_single: assert property (p_single) else $error("single-wire chosen without pulse");
  property p_chan;
    s_boost_up |-> chan_en_o == ~{sink_feedback_pin_two_i, sink_feedback_pin_one_i};
  endproperty
  a_chan: assert property (p_chan) else $error("grounded channel left on");
  property p_soft;
    s_boost_up |-> reduced_limit_o;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start without reduced limit");
  property p_boost_chan;
    boost_en_o |-> chan_en_o != 2'b00;
  endproperty
  a_boost_chan: assert property (p_boost_chan) else $error("boost with no channel");
  property p_off;
    !regulator_on_o |-> !boost_en_o && brightness_code_o == CODE_DEFAULT;
  endproperty
  a_off: assert property (p_off) else $error("shutdown state not cleared");
  property p_en_off;
    int'(en_low_cnt) > EN_LIM |-> !regulator_on_o;
  endproperty
  a_en_off: assert property (p_en_off) else $error("enable low did not shut down");
  property p_frame;
    s_good_frame |=> brightness_code_o == $past(frame_i[CODE_W-1:0]);
  endproperty
  a_frame: assert property (p_frame) else $error("code not taken from frame");
  property p_bad_addr;
    frame_valid_i && frame_i[23:16] != DEVICE_ADDR |=> $stable(brightness_code_o);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("foreign frame changed code");
endmodule

bind bsds_top bsds_checker #(.P_TICK_CYCLES(P_TICK_CYCLES), .P_EN_OFF_US(P_EN_OFF_US)) chk (.*);
`default_nettype wire

/* File: test/bsds_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// Host processor driving the enable and dimming pins
// ********
module bsds_host_model
  import bsds_pkg::*;
(
  input  wire logic               clk_i,
  output var  logic               enable_pin_o,
  output var  logic               dimming_pin_o,
  output var  logic               frame_valid_o,
  output var  logic [FRAME_W-1:0] frame_o
);
  // Idle: enable low, dimming held high as the host would keep it.
  initial begin
    enable_pin_o  = 1'b0;
    dimming_pin_o = 1'b1;
    frame_valid_o = 1'b0;
    frame_o       = '0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // A short low first guarantees a fresh rising edge, even from a dimming shutdown.
  task automatic power_up(input bit single);
    @(posedge clk_i);
    enable_pin_o <= 1'b0;
    @(posedge clk_i);
    enable_pin_o <= 1'b1;
    if (single) begin
      hold(120);
      enable_pin_o <= 1'b0;
      hold(270);
      enable_pin_o <= 1'b1;
    end
  endtask

  // Hold one pin low for n cycles; dimming always comes back high.
  task automatic pin_low(input bit dim, input int n);
    @(posedge clk_i);
    if (dim) begin
      dimming_pin_o <= 1'b0;
    end else begin
      enable_pin_o <= 1'b0;
    end
    hold(n);
    dimming_pin_o <= 1'b1;
  endtask

  // A whole frame at once; outside it the bus shows the inverse, not stale data.
  task automatic send(input logic [ADDR_W-1:0] adr, input logic [CODE_W-1:0] code);
    @(posedge clk_i);
    frame_o       <= {adr, 7'h00, code};
    frame_valid_o <= 1'b1;
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    frame_o       <= ~frame_o;
  endtask
endmodule
`default_nettype wire

/* File: test/backlight_startup_dimming_select_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module backlight_startup_dimming_select_tb;
  import bsds_pkg::*;
  // ********
  // Shortened durations, in cycles of one tick each
  // ********
  localparam logic [TMR_W-1:0] WIN = 15'd400;  // Still above the 390 cycles of the pattern.
  localparam logic [TMR_W-1:0] EN_OFF = 15'd300;  // Above the detect low pulse.
  logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0]   wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i, wb_dat_o, rd;
  logic               supply_ok_i, enable_pin_i, dimming_pin_i, frame_valid_i;
  logic               sink_feedback_pin_one_i, sink_feedback_pin_two_i;
  logic [FRAME_W-1:0] frame_i;
  logic               regulator_on_o, single_wire_sel_o, pwm_sel_o, boost_en_o;
  logic               reduced_limit_o;
  logic [1:0]         chan_en_o, fb;
  logic [CODE_W-1:0]  brightness_code_o, code;
  int                 errors = 0, total_checks = 0, cycles = 0;
  logic               sel0 = 1'b1;  // Byte select 0 of the next bus request.

  bsds_top #(.P_TICK_CYCLES(1), .P_WINDOW_US(WIN), .P_EN_OFF_US(EN_OFF),
    .P_DIM_OFF_US(15'd80), .P_REDUCED_US(15'd20)) uut (.*);
  bsds_host_model host (.clk_i, .enable_pin_o(enable_pin_i), .dimming_pin_o(dimming_pin_i),
    .frame_valid_o(frame_valid_i), .frame_o(frame_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Cut a hang short: the whole run needs about 3300 cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Wait n edges, then step off the edge so outputs have settled.
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Classic cycle: hold everything until ack is seen, release at that edge.
  task automatic wb_rw(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, wd};
    wb_sel_i <= {3'($urandom), sel0};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;  // A missing ack counts as a mismatch.
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  // Grounded feedback pins switch their own channel off.
  function automatic logic [1:0] exp_chan(input logic [1:0] pins);
    return ~pins;
  endfunction

  initial begin
    {rst_i, supply_ok_i, wb_sel_i} = {2'b10, 4'hF};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {sink_feedback_pin_two_i, sink_feedback_pin_one_i} = 2'b00;
    void'($urandom(57116));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rw(1'b0, REG_CODE, 32'h0);
    check("code_reg", CODE_DEFAULT, rd);
    wb_rw(1'b0, REG_STATUS, 32'h0);
    check("status", 32'h0, rd);
    wb_rw(1'b0, 8'h3C, 32'h0);
    check("unmapped", 32'h0, rd);
    host.power_up(1'b0);  // No supply yet.
    wt(20);
    check("no_supply", 1'b0, regulator_on_o);
    @(posedge clk_i);
    supply_ok_i <= 1'b1;
    // Pulse-width startups with random channels, ended by enable, then by dimming, then by supply.
    for (int i = 0; i < 3; i++) begin
      fb = 2'($urandom_range(2));
      @(posedge clk_i);
      {sink_feedback_pin_two_i, sink_feedback_pin_one_i} <= fb;
      host.power_up(1'b0);
      wt(WIN - 10);
      check("reg_on", 1'b1, regulator_on_o);
      check("pwm_early", 1'b0, pwm_sel_o);
      wt(20);
      check("pwm_sel", 2'b01, {single_wire_sel_o, pwm_sel_o});
      check("chan_en", exp_chan(fb), chan_en_o);
      check("soft", 2'b11, {boost_en_o, reduced_limit_o});
      wt(30);
      check("normal", 2'b10, {boost_en_o, reduced_limit_o});
      host.send(DEVICE_ADDR, 9'h055);
      wt(2);
      check("pwm_code", CODE_DEFAULT, brightness_code_o);
      // The third startup is ended by a supply dip instead of a pin.
      if (i < 2) begin
        host.pin_low(i[0], EN_OFF + 20);
      end else begin
        @(posedge clk_i);
        supply_ok_i <= 1'b0;
        @(posedge clk_i);
        supply_ok_i <= 1'b1;
      end
      wt(1);
      check("off", 1'b0, regulator_on_o);
    end
    // Single-wire startup, commands, then a forced shutdown.
    @(posedge clk_i);
    {sink_feedback_pin_two_i, sink_feedback_pin_one_i} <= 2'b00;
    host.power_up(1'b1);
    wt(40);
    check("single_sel", 2'b10, {single_wire_sel_o, pwm_sel_o});
    for (int i = 0; i < 3; i++) begin
      code = CODE_W'($urandom);
      host.send(DEVICE_ADDR, code);
      wt(1);
      check("code", code, brightness_code_o);
    end
    host.send(8'h8E, ~code);
    wt(2);
    check("bad_addr", code, brightness_code_o);
    // A control write without byte select 0 must leave the device on.
    sel0 = 1'b0;
    wb_rw(1'b1, REG_CTRL, 32'h1);
    sel0 = 1'b1;
    wt(2);
    check("sel_ignored", 1'b1, regulator_on_o);
    wb_rw(1'b1, REG_CTRL, 32'h1);
    wt(2);
    check("hold_off", 1'b0, regulator_on_o);
    check("code_back", CODE_DEFAULT, brightness_code_o);
    wb_rw(1'b1, REG_CTRL, 32'h0);
    // Both channels grounded: the sequence stops short of switching.
    @(posedge clk_i);
    {sink_feedback_pin_two_i, sink_feedback_pin_one_i} <= 2'b11;
    host.power_up(1'b0);
    wt(WIN + 10);
    wb_rw(1'b0, REG_STATUS, 32'h0);
    check("halt", 32'h425, rd);
    host.pin_low(1'b0, EN_OFF + 20);
    wt(1);
    check("halt_off", 1'b0, regulator_on_o);
    complete_run();
  end
endmodule
`default_nettype wire
